// *** uebm_endpoint.sv ***
// Operation
// - dual OUT bank: next full bank flags immediately
// - auto switch frees OUT bank on last read
// - DMA auto OUT: banks freed and switched
// - DMA auto: zero-length OUT dropped, flagged
// - IN bank free sets ready and owned
// - releasing IN bank queues it and switches
// - IN access allowed until bank full
// - auto switch queues IN bank when full
// - dual IN bank: next free bank flags immediately
// - DMA auto IN: filled banks queued and switched
// - kill control discards last written IN bank
// - iso switch changes banks at each frame start while the current IN bank is not full
// - missing frame start gets substitute, number increments
// - IN request on empty bank raises underflow
// - OUT packet into full banks is dropped
// - corrupted OUT packet flags error, still received
// - oversize OUT packet: overflow, ack, truncated store
// - full OUT bank sets received and owned
// - OUT access allowed while unread data remains
`default_nettype none
module uebm_endpoint
  import uebm_pkg::*;
#(
  parameter int unsigned FRAME_TIMEOUT = FRAME_TIMEOUT_CYC
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output var  logic [31:0]       reg_rdata,
  input  wire uebm_out_pkt_s     usb_out,
  output var  logic              usb_out_ack_ff,
  output var  logic              usb_out_nak_ff,
  input  wire logic              usb_in_req,
  output var  logic              usb_in_valid_ff,
  output var  logic [7:0]        usb_in_data,
  output var  logic              usb_in_last_ff,
  output var  logic              usb_in_zlp_ff,
  output var  logic              usb_in_nak_ff,
  input  wire logic              usb_sof,
  input  wire logic [FNUM_W-1:0] usb_sof_frame,
  input  wire logic              dma_rd_req,
  output var  logic              dma_rd_grant,
  output var  logic              dma_rd_valid_ff,
  output var  logic [7:0]        dma_rd_data,
  input  wire logic              dma_wr_req,
  input  wire logic [7:0]        dma_wr_data,
  output var  logic              dma_wr_grant,
  output var  logic              endpoint_interrupt_ff
);

  uebm_cfg_s         cfg_ff;
  logic [NUM_BANKS-1:0] full_ff;
  logic [PTR_W-1:0]  cnt_ff [NUM_BANKS];
  logic              cur_ff;
  logic              usb_bank_ff;
  logic [PTR_W-1:0]  cpu_ptr_ff;
  logic              out_received_ff;
  logic              in_ready_ff;
  logic              zls_ff;
  logic              underflow_ff;
  logic              overflow_ff;
  logic              stall_err_ff;
  logic              frame_start_ff;
  logic              owned_prev_ff;
  logic              cur_prev_ff;
  logic              out_active_ff;
  logic              out_drop_ff;
  logic [PTR_W-1:0]  out_ptr_ff;
  logic              in_busy_ff;
  logic [PTR_W-1:0]  in_idx_ff;
  logic [31:0]       rdata_ff;
  logic              rd_data_sel_ff;

  logic              wr_cfg, wr_stat, wr_ctrl, wr_data, rd_data;
  logic              dir_in, dma_mode, auto_mode, iso_mode;
  logic              bank_owned, access_allowed;
  logic [PTR_W-1:0]  cur_cnt;
  logic              cpu_rd_go, cpu_wr_go;
  logic              sw_release, auto_out_free, auto_in_queue, iso_switch;
  logic              cpu_done, kill_go, kill_bank;
  logic [PTR_W-1:0]  queue_cnt;
  logic              own_event;
  logic              usb_fill, usb_done, out_byte_ok, in_issue, in_start;
  logic              sof_event;
  logic [FNUM_W-1:0] frame_number;
  logic [STAT_W-1:0] stat_clr, stat_v;
  logic [7:0]        ram_a_rdata, ram_b_rdata, cpu_wbyte;
  uebm_maddr_t       ram_b_addr;

  // register port decode
  assign wr_cfg  = reg_wr && (reg_addr == OFS_CFG);
  assign wr_stat = reg_wr && (reg_addr == OFS_STAT);
  assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
  assign wr_data = reg_wr && (reg_addr == OFS_DATA);
  assign rd_data = reg_rd && (reg_addr == OFS_DATA);

  assign dir_in    = cfg_ff.dir_in;
  assign dma_mode  = cfg_ff.data_flow_dma;
  assign auto_mode = cfg_ff.auto_bank_switch;
  assign iso_mode  = cfg_ff.dir_in && cfg_ff.iso_frame_switch;
  assign cur_cnt   = cnt_ff[cur_ff];

  // the cpu owns the current bank when it is full (out) or free (in)
  assign bank_owned = dir_in ? !full_ff[cur_ff] : full_ff[cur_ff];

  // room to write, or unread bytes left, in the current bank
  always_comb begin
    if (dir_in) begin
      access_allowed = !full_ff[cur_ff] && (cpu_ptr_ff < BANK_BYTES);
    end else begin
      access_allowed = full_ff[cur_ff] && (cpu_ptr_ff < cur_cnt);
    end
  end

  // in dma mode the data port is dead; the dma strobes take its place
  assign dma_rd_grant = dma_mode && !dir_in && access_allowed;
  assign dma_wr_grant = dma_mode && dir_in && access_allowed;
  assign cpu_rd_go = !dir_in && access_allowed && (dma_mode ? dma_rd_req : rd_data);
  assign cpu_wr_go = dir_in && access_allowed && (dma_mode ? dma_wr_req : wr_data);
  assign cpu_wbyte = dma_mode ? dma_wr_data : reg_wdata[7:0];

  // software release is ignored whenever hardware does the switching
  assign sw_release = wr_ctrl && reg_wdata[CT_RELEASE] && !auto_mode && !iso_mode
                      && bank_owned;
  assign auto_out_free = !dir_in && auto_mode && cpu_rd_go
                         && (cpu_ptr_ff + 7'h01 == cur_cnt);
  assign auto_in_queue = dir_in && auto_mode && cpu_wr_go
                         && (cpu_ptr_ff + 7'h01 == BANK_BYTES);
  assign iso_switch = iso_mode && sof_event && !full_ff[cur_ff];

  // the newest written bank; with both full the older one is still due out
  assign kill_bank = cfg_ff.two_banks ? ~cur_ff : cur_ff;
  assign kill_go   = wr_ctrl && reg_wdata[CT_KILL] && dir_in && full_ff[kill_bank]
                     && !(in_busy_ff && (usb_bank_ff == kill_bank));
  assign cpu_done  = (sw_release || auto_out_free || auto_in_queue || iso_switch)
                     && !kill_go;
  assign queue_cnt = auto_in_queue ? BANK_BYTES : cpu_ptr_ff;

  // bus-side events
  assign out_byte_ok = !dir_in && out_active_ff && !out_drop_ff && usb_out.valid
                       && (out_ptr_ff < BANK_BYTES);
  assign usb_fill = !dir_in && out_active_ff && !out_drop_ff && usb_out.done
                    && !(dma_mode && auto_mode && (out_ptr_ff == 7'h00));
  assign in_start = dir_in && usb_in_req && !in_busy_ff && full_ff[usb_bank_ff];
  assign in_issue = in_busy_ff && (in_idx_ff < cnt_ff[usb_bank_ff]);
  assign usb_done = in_busy_ff && (in_idx_ff == cnt_ff[usb_bank_ff]);

  // configuration register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_ff <= CFG_RESET;
    end else if (wr_cfg) begin
      cfg_ff <= uebm_cfg_s'(reg_wdata[6:0]);
    end
  end

  // bank occupancy and byte counts, one slot per bank
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      full_ff <= '0;
      for (int b = 0; b < NUM_BANKS; b++) begin
        cnt_ff[b] <= '0;
      end
    end else begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        if (usb_fill && (usb_bank_ff == 1'(b))) begin
          full_ff[b] <= 1'b1;
          cnt_ff[b]  <= out_ptr_ff;
        end
        if (usb_done && (usb_bank_ff == 1'(b))) begin
          full_ff[b] <= 1'b0;
        end
        if (cpu_done && (cur_ff == 1'(b))) begin
          full_ff[b] <= dir_in;
          if (dir_in) begin
            cnt_ff[b] <= queue_cnt;
          end
        end
        if (kill_go && (kill_bank == 1'(b))) begin
          full_ff[b] <= 1'b0;
        end
      end
    end
  end

  // cpu-side bank select and byte pointer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur_ff     <= 1'b0;
      cpu_ptr_ff <= '0;
    end else if (kill_go) begin
      cur_ff     <= kill_bank;
      cpu_ptr_ff <= '0;
    end else if (cpu_done) begin
      cur_ff     <= cfg_ff.two_banks ? ~cur_ff : cur_ff;
      cpu_ptr_ff <= '0;
    end else if (cpu_rd_go || cpu_wr_go) begin
      cpu_ptr_ff <= cpu_ptr_ff + 7'h01;
    end
  end

  // bus-side bank select follows fills (out) and sends (in)
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      usb_bank_ff <= 1'b0;
    end else if ((usb_fill || usb_done) && cfg_ff.two_banks) begin
      usb_bank_ff <= ~usb_bank_ff;
    end
  end

  // out packet reception; a busy bank makes the whole packet vanish
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_active_ff  <= 1'b0;
      out_drop_ff    <= 1'b0;
      out_ptr_ff     <= '0;
      usb_out_ack_ff <= 1'b0;
      usb_out_nak_ff <= 1'b0;
    end else begin
      usb_out_ack_ff <= out_active_ff && !out_drop_ff && usb_out.done;
      usb_out_nak_ff <= out_active_ff && out_drop_ff && usb_out.done;
      if (usb_out.start && !dir_in) begin
        out_active_ff <= 1'b1;
        out_drop_ff   <= full_ff[usb_bank_ff];
        out_ptr_ff    <= '0;
      end else if (usb_out.done) begin
        out_active_ff <= 1'b0;
        out_drop_ff   <= 1'b0;
      end else if (out_byte_ok) begin
        out_ptr_ff <= out_ptr_ff + 7'h01;
      end
    end
  end

  // in packet transmission, one byte per cycle after a one-cycle read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      in_busy_ff      <= 1'b0;
      in_idx_ff       <= '0;
      usb_in_valid_ff <= 1'b0;
      usb_in_last_ff  <= 1'b0;
      usb_in_zlp_ff   <= 1'b0;
      usb_in_nak_ff   <= 1'b0;
    end else begin
      usb_in_valid_ff <= in_issue;
      usb_in_last_ff  <= in_issue && (in_idx_ff + 7'h01 == cnt_ff[usb_bank_ff]);
      usb_in_zlp_ff   <= in_start && (cnt_ff[usb_bank_ff] == 7'h00);
      usb_in_nak_ff   <= dir_in && usb_in_req && !in_busy_ff && !full_ff[usb_bank_ff];
      if (in_start) begin
        in_busy_ff <= 1'b1;
        in_idx_ff  <= '0;
      end else if (usb_done) begin
        in_busy_ff <= 1'b0;
      end else if (in_issue) begin
        in_idx_ff <= in_idx_ff + 7'h01;
      end
    end
  end

  // ownership edges raise the received / ready flags, also on a bank switch
  assign own_event = bank_owned && (!owned_prev_ff || (cur_ff != cur_prev_ff));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      owned_prev_ff <= 1'b0;
      cur_prev_ff   <= 1'b0;
    end else begin
      owned_prev_ff <= bank_owned;
      cur_prev_ff   <= cur_ff;
    end
  end

  // sticky flags: a set in the clearing cycle wins
  assign stat_clr = wr_stat ? (reg_wdata[STAT_W-1:0] & STAT_W1C_MASK) : '0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_received_ff <= 1'b0;
      in_ready_ff     <= 1'b0;
    end else begin
      out_received_ff <= (!dir_in && own_event)
                         || (out_received_ff && !stat_clr[ST_OUT_RCV]);
      in_ready_ff     <= (dir_in && own_event)
                         || (in_ready_ff && !stat_clr[ST_IN_RDY]);
    end
  end

  // error and event flags
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      zls_ff         <= 1'b0;
      underflow_ff   <= 1'b0;
      overflow_ff    <= 1'b0;
      stall_err_ff   <= 1'b0;
      frame_start_ff <= 1'b0;
    end else begin
      zls_ff <= (!dir_in && out_active_ff && !out_drop_ff && usb_out.done && !usb_fill)
                || (zls_ff && !stat_clr[ST_ZLS]);
      underflow_ff <= usb_in_nak_ff
                      || (underflow_ff && !stat_clr[ST_UNDERFLOW]);
      overflow_ff <= (!dir_in && out_active_ff && !out_drop_ff && usb_out.valid
                      && (out_ptr_ff == BANK_BYTES))
                     || (overflow_ff && !stat_clr[ST_OVERFLOW]);
      stall_err_ff <= (usb_fill && usb_out.crc_err)
                      || (stall_err_ff && !stat_clr[ST_STALL_ERR]);
      frame_start_ff <= sof_event
                        || (frame_start_ff && !stat_clr[ST_FRAME]);
    end
  end

  // endpoint interrupt from the enabled processing flags
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      endpoint_interrupt_ff <= 1'b0;
    end else begin
      endpoint_interrupt_ff <= (!dir_in && out_received_ff && cfg_ff.out_received_enable)
                               || (dir_in && in_ready_ff && cfg_ff.in_ready_enable);
    end
  end

  // status word as software sees it
  always_comb begin
    stat_v               = '0;
    stat_v[ST_OUT_RCV]   = out_received_ff;
    stat_v[ST_IN_RDY]    = in_ready_ff;
    stat_v[ST_OWNED]     = bank_owned;
    stat_v[ST_ACCESS]    = access_allowed;
    stat_v[ST_ZLS]       = zls_ff;
    stat_v[ST_UNDERFLOW] = underflow_ff;
    stat_v[ST_OVERFLOW]  = overflow_ff;
    stat_v[ST_STALL_ERR] = stall_err_ff;
    stat_v[ST_FRAME]     = frame_start_ff;
    stat_v[ST_BUSY]      = |full_ff;
  end

  // read data one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff       <= '0;
      rd_data_sel_ff <= 1'b0;
    end else begin
      rd_data_sel_ff <= rd_data;
      rdata_ff       <= '0;
      if (reg_rd) begin
        case (reg_addr)
          OFS_CFG:   rdata_ff <= {25'h0000000, cfg_ff};
          OFS_STAT:  rdata_ff <= {22'h000000, stat_v};
          OFS_BCNT:  rdata_ff <= {25'h0000000, dir_in ? cpu_ptr_ff : cur_cnt};
          OFS_FRAME: rdata_ff <= {21'h000000, frame_number};
          default:   rdata_ff <= '0;
        endcase
      end
    end
  end

  // a data-port read returns the ram byte fetched in the strobe cycle
  assign reg_rdata = rd_data_sel_ff ? {24'h000000, ram_a_rdata} : rdata_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dma_rd_valid_ff <= 1'b0;
    end else begin
      dma_rd_valid_ff <= dma_mode && cpu_rd_go;
    end
  end

  assign dma_rd_data = ram_a_rdata;
  assign usb_in_data = ram_b_rdata;

  // port b serves the bus side: fill on out, drain on in
  assign ram_b_addr = dir_in ? {usb_bank_ff, in_idx_ff[IDX_W-1:0]}
                             : {usb_bank_ff, out_ptr_ff[IDX_W-1:0]};

  uebm_bank_ram u_ram (
    .clk     (clk),
    .a_addr  ({cur_ff, cpu_ptr_ff[IDX_W-1:0]}),
    .a_we    (cpu_wr_go),
    .a_wdata (cpu_wbyte),
    .a_rdata (ram_a_rdata),
    .b_addr  (ram_b_addr),
    .b_we    (out_byte_ok),
    .b_wdata (usb_out.data),
    .b_rdata (ram_b_rdata)
  );

  uebm_frame_timer #(
    .TIMEOUT_CYC (FRAME_CNT_W'(FRAME_TIMEOUT))
  ) u_frame (
    .clk             (clk),
    .resetn          (resetn),
    .sof_seen        (usb_sof),
    .sof_frame       (usb_sof_frame),
    .sof_event_ff    (sof_event),
    .frame_number_ff (frame_number)
  );

endmodule
`default_nettype wire

// *** uebm_pkg.sv ***
`default_nettype none
package uebm_pkg;

  // register offsets on the byte-addressed control port
  localparam logic [7:0] OFS_CFG   = 8'h00;
  localparam logic [7:0] OFS_STAT  = 8'h04;
  localparam logic [7:0] OFS_CTRL  = 8'h08;
  localparam logic [7:0] OFS_BCNT  = 8'h0C;
  localparam logic [7:0] OFS_DATA  = 8'h10;
  localparam logic [7:0] OFS_FRAME = 8'h14;

  // bank geometry: two banks of 64 bytes each
  localparam int unsigned NUM_BANKS = 2;
  localparam int unsigned IDX_W     = 6;
  localparam int unsigned PTR_W     = 7;
  localparam int unsigned MEM_AW    = 7;
  localparam logic [PTR_W-1:0] BANK_BYTES = 7'h40;

  // status register bit positions
  localparam int unsigned STAT_W       = 10;
  localparam int unsigned ST_OUT_RCV   = 0;
  localparam int unsigned ST_IN_RDY    = 1;
  localparam int unsigned ST_OWNED     = 2;
  localparam int unsigned ST_ACCESS    = 3;
  localparam int unsigned ST_ZLS       = 4;
  localparam int unsigned ST_UNDERFLOW = 5;
  localparam int unsigned ST_OVERFLOW  = 6;
  localparam int unsigned ST_STALL_ERR = 7;
  localparam int unsigned ST_FRAME     = 8;
  localparam int unsigned ST_BUSY      = 9;
  // bits that a written one clears
  localparam logic [STAT_W-1:0] STAT_W1C_MASK = 10'h1F3;

  // control register action bits
  localparam int unsigned CT_RELEASE = 0;
  localparam int unsigned CT_KILL    = 1;

  // frame timing at 250 MHz
  localparam int unsigned FNUM_W          = 11;
  localparam int unsigned FRAME_CNT_W     = 18;
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned FRAME_PERIOD_NS = 1000000;
  localparam int unsigned SOF_SLACK_NS    = 2000;
  localparam int unsigned FRAME_TIMEOUT_CYC =
    (FRAME_PERIOD_NS + SOF_SLACK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic in_ready_enable;
    logic out_received_enable;
    logic iso_frame_switch;
    logic data_flow_dma;
    logic auto_bank_switch;
    logic two_banks;
    logic dir_in;
  } uebm_cfg_s;

  localparam uebm_cfg_s CFG_RESET = 7'h00;

  // received packet stream from the bus-side protocol engine
  typedef struct packed {
    logic       start;
    logic       valid;
    logic [7:0] data;
    logic       done;
    logic       crc_err;
  } uebm_out_pkt_s;

  typedef logic [MEM_AW-1:0] uebm_maddr_t;

endpackage
`default_nettype wire

// *** uebm_bank_ram.sv ***
`default_nettype none
module uebm_bank_ram
  import uebm_pkg::*;
(
  input  wire logic        clk,
  input  wire uebm_maddr_t a_addr,
  input  wire logic        a_we,
  input  wire logic [7:0]  a_wdata,
  output var  logic [7:0]  a_rdata,
  input  wire uebm_maddr_t b_addr,
  input  wire logic        b_we,
  input  wire logic [7:0]  b_wdata,
  output var  logic [7:0]  b_rdata
);

  logic [7:0] mem [0:(1<<MEM_AW)-1];

  // both ports in one process so the array has a single driver
  always_ff @(posedge clk) begin
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
    if (b_we) begin
      mem[b_addr] <= b_wdata;
    end
    a_rdata <= mem[a_addr];
    b_rdata <= mem[b_addr];
  end

endmodule
`default_nettype wire

// *** uebm_frame_timer.sv ***
`default_nettype none
module uebm_frame_timer
  import uebm_pkg::*;
#(
  parameter logic [FRAME_CNT_W-1:0] TIMEOUT_CYC = FRAME_CNT_W'(FRAME_TIMEOUT_CYC)
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              sof_seen,
  input  wire logic [FNUM_W-1:0] sof_frame,
  output var  logic              sof_event_ff,
  output var  logic [FNUM_W-1:0] frame_number_ff
);

  logic                   armed_ff;
  logic [FRAME_CNT_W-1:0] cnt_ff;
  logic                   pseudo;

  // no substitute frames before the first real one is seen
  assign pseudo = armed_ff && !sof_seen && (cnt_ff == TIMEOUT_CYC - 1'b1);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      armed_ff <= 1'b0;
    end else if (sof_seen) begin
      armed_ff <= 1'b1;
    end
  end

  // cycles since the last frame start, real or substitute
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= '0;
    end else if (sof_seen || pseudo) begin
      cnt_ff <= '0;
    end else if (armed_ff) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // frame event and number
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sof_event_ff    <= 1'b0;
      frame_number_ff <= '0;
    end else begin
      sof_event_ff <= sof_seen || pseudo;
      if (sof_seen) begin
        frame_number_ff <= sof_frame;
      end else if (pseudo) begin
        frame_number_ff <= frame_number_ff + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// *** uebm_chk.sv ***
`default_nettype none
module uebm_chk
  import uebm_pkg::*;
#(
  parameter int unsigned FRAME_TIMEOUT = 50
) (
  input wire logic          clk,
  input wire logic          resetn,
  input wire uebm_out_pkt_s usb_out,
  input wire logic          usb_out_ack_ff,
  input wire logic          usb_out_nak_ff,
  input wire logic          usb_in_req,
  input wire logic          usb_in_valid_ff,
  input wire logic          usb_in_last_ff,
  input wire logic          usb_in_zlp_ff,
  input wire logic          usb_in_nak_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // out side: each packet answered exactly once, right after done
  a_out_answer: assert property (usb_out.done |=> usb_out_ack_ff ^ usb_out_nak_ff)
    else $error("out packet not answered");
  a_ack_cause: assert property (usb_out_ack_ff |-> $past(usb_out.done))
    else $error("ack without done");
  // in side: nak and zlp follow a token, bytes run without gaps
  a_nak_cause: assert property (usb_in_nak_ff |-> $past(usb_in_req))
    else $error("nak without token");
  a_nak_nodata: assert property (usb_in_nak_ff |-> !usb_in_valid_ff && !usb_in_zlp_ff)
    else $error("nak with data");
  a_zlp_cause: assert property (usb_in_zlp_ff |-> $past(usb_in_req))
    else $error("zlp without token");
  a_first_byte: assert property ($rose(usb_in_valid_ff) |-> $past(usb_in_req, 2))
    else $error("in data not two cycles after token");
  a_byte_run: assert property (usb_in_valid_ff && !usb_in_last_ff |=> usb_in_valid_ff)
    else $error("gap inside in packet");
  a_last_ends: assert property (usb_in_last_ff |-> usb_in_valid_ff ##1 !usb_in_valid_ff)
    else $error("last byte misplaced");
  c_ack: cover property (usb_out_ack_ff);
  c_nak: cover property (usb_out_nak_ff);
  c_last: cover property (usb_in_last_ff);
endmodule
bind uebm_endpoint uebm_chk #(.FRAME_TIMEOUT(FRAME_TIMEOUT)) uebm_chk_i (.clk, .resetn,
  .usb_out, .usb_out_ack_ff, .usb_out_nak_ff, .usb_in_req, .usb_in_valid_ff,
  .usb_in_last_ff, .usb_in_zlp_ff, .usb_in_nak_ff);
`default_nettype wire

// *** uebm_host.sv ***
`default_nettype none
module uebm_host
  import uebm_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          go,
  input  wire logic [6:0]    len,
  input  wire logic          crc,
  input  wire logic          in_go,
  output var uebm_out_pkt_s usb_out,
  output var logic          usb_in_req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial usb_out = '0;
  initial usb_in_req = 1'b0;
  // one packet per go: start, bytes A0 upward, done; data inverted on done, then held when idle
  always @(posedge clk) begin
    usb_in_req <= in_go;
    if (go) begin
      usb_out <= {2'b10, 8'h00, 2'b00};
      for (int i = 0; i < int'(len); i++) begin
        @(posedge clk);
        usb_out <= {2'b01, 8'(8'hA0 + i), 2'b00};
      end
      @(posedge clk);
      usb_out <= {2'b00, ~usb_out.data, 1'b1, crc};
      @(posedge clk);
      usb_out <= {2'b00, usb_out.data, 2'b00};
    end
  end
endmodule
`default_nettype wire

// *** uebm_tb.sv ***
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin bad_count++; \
  $display("BAD %s exp %0h got %0h", n, e, s); end end
module tb
  import uebm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic          clk = 1'b0;
  logic          resetn = 1'b0;
  logic          reg_wr = 1'b0;
  logic          reg_rd = 1'b0;
  logic          go = 1'b0;
  logic          crc = 1'b0;
  logic          in_go = 1'b0;
  logic          sof = 1'b0;
  logic          dmar = 1'b0;
  logic          irq;
  logic [6:0]    len = '0;
  logic [7:0]    reg_addr = '0;
  logic [31:0]   reg_wdata = '0;
  logic [31:0]   reg_rdata, d;
  uebm_out_pkt_s usb_out;
  logic          usb_out_ack_ff, usb_out_nak_ff, usb_in_req, usb_in_valid_ff;
  logic          usb_in_last_ff, usb_in_zlp_ff, usb_in_nak_ff;
  logic [7:0]    usb_in_data, dma_rd_data;
  logic [7:0]    ib [2] = '{8'h5A, 8'hC3};
  logic [39:0]   rows [6] = '{{OFS_CFG, 32'h0}, {OFS_STAT, 32'h0}, {OFS_CTRL, 32'h0},
                              {OFS_BCNT, 32'h0}, {OFS_FRAME, 32'h0}, {8'h20, 32'h0}};
  int            bad_count = 0;
  int            n_checks = 0;

  // short frame timeout keeps the substitute frame reachable in sim
  uebm_endpoint #(.FRAME_TIMEOUT(50)) uebm_endpoint_i (.clk, .resetn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .usb_out, .usb_out_ack_ff, .usb_out_nak_ff, .usb_in_req,
    .usb_in_valid_ff, .usb_in_data, .usb_in_last_ff, .usb_in_zlp_ff, .usb_in_nak_ff,
    .usb_sof(sof), .usb_sof_frame(11'h000), .dma_rd_req(dmar), .dma_rd_grant(),
    .dma_rd_valid_ff(), .dma_rd_data, .dma_wr_req(1'b0), .dma_wr_data(8'h00),
    .dma_wr_grant(), .endpoint_interrupt_ff(irq));
  uebm_host uebm_host_i (.clk, .go, .len, .crc, .in_go, .usb_out, .usb_in_req);

  initial forever #2 clk = ~clk;

  task automatic conclude();
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // one idle edge so a following write never reassigns the strobe in this step
    @(posedge clk);
  endtask
  // read data sampled off the edge, then realign so drives stay on edges
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk);
    `CHK($sformatf("reg%0h", a), e, d & m)
  endtask
  // host out packet, bounded wait for the handshake
  task automatic pkt(input logic [6:0] n, input logic c, input logic ak);
    int k;
    go <= 1'b1;
    len <= n;
    crc <= c;
    @(posedge clk);
    go <= 1'b0;
    for (k = 0; k < 200; k++) begin
      @(posedge clk);
      #1 if (usb_out_ack_ff || usb_out_nak_ff) break;
    end
    if (k == 200) begin
      bad_count++;
      conclude();
    end else begin
      `CHK("ack", ak, usb_out_ack_ff)
      repeat (3) @(posedge clk);
    end
  endtask
  // host in token; s collects nak and zero-length packet sent
  task automatic inrx(input int n, input logic [1:0] e);
    int k, j;
    logic [1:0] s;
    j = 0;
    s = 2'b00;
    in_go <= 1'b1;
    @(posedge clk);
    in_go <= 1'b0;
    for (k = 0; k < 12; k++) begin
      @(posedge clk);
      #1 s = s | {usb_in_nak_ff, usb_in_zlp_ff};
      if (usb_in_valid_ff) `CHK("in_byte", ib[j], usb_in_data)
      if (usb_in_valid_ff) j++;
    end
    @(posedge clk);
    `CHK("in_count", n, j)
    `CHK("in_end", e, s)
  endtask

  initial begin
    int i;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) rc(rows[i][39:32], 32'hFFFFFFFF, rows[i][31:0]);
    // manual out: fill, refuse a second packet, drain, release
    pkt(7'd3, 1'b0, 1'b1);
    rc(OFS_STAT, 32'h0F, 32'h0D);
    rc(OFS_BCNT, 32'h7F, 32'h03);
    pkt(7'd2, 1'b0, 1'b0);
    for (i = 0; i < 3; i++) rc(OFS_DATA, 32'hFF, 32'(8'hA0 + i));
    rc(OFS_STAT, 32'h08, 32'h0);
    wr(OFS_STAT, 32'h1);
    wr(OFS_CTRL, 32'h1);
    rc(OFS_STAT, 32'h0F, 32'h0);
    // corrupted packet still reported as received
    pkt(7'd1, 1'b1, 1'b1);
    rc(OFS_STAT, 32'h81, 32'h81);
    rc(OFS_DATA, 32'hFF, 32'hA0);
    wr(OFS_STAT, 32'h1F3);
    wr(OFS_CTRL, 32'h1);
    // oversize packet truncated, then auto switch frees on last read
    pkt(7'd65, 1'b0, 1'b1);
    rc(OFS_STAT, 32'h41, 32'h41);
    rc(OFS_BCNT, 32'h7F, 32'h40);
    wr(OFS_CFG, 32'h4);
    for (i = 0; i < 64; i++) rc(OFS_DATA, 32'hFF, 32'(8'hA0 + i));
    rc(OFS_STAT, 32'h04, 32'h0);
    // dma without auto switch: engine drains, cpu releases once access drops
    wr(OFS_CFG, 32'h8);
    pkt(7'd2, 1'b0, 1'b1);
    dmar <= 1'b1;
    repeat (2) @(posedge clk);
    dmar <= 1'b0;
    #1 `CHK("dma_byte", 8'hA1, dma_rd_data)
    @(posedge clk);
    rc(OFS_STAT, 32'h08, 32'h0);
    wr(OFS_CTRL, 32'h1);
    rc(OFS_STAT, 32'h04, 32'h0);
    // manual in: free bank offered, filled, sent, then underflow and zlp
    wr(OFS_STAT, 32'h1F3);
    wr(OFS_CFG, 32'h41);
    repeat (3) @(posedge clk);
    rc(OFS_STAT, 32'h0E, 32'h0E);
    `CHK("irq", 1'b1, irq)
    wr(OFS_DATA, 32'h5A);
    wr(OFS_DATA, 32'hC3);
    rc(OFS_BCNT, 32'h7F, 32'h02);
    wr(OFS_STAT, 32'h2);
    wr(OFS_CTRL, 32'h1);
    inrx(2, 2'b00);
    rc(OFS_STAT, 32'h06, 32'h06);
    inrx(0, 2'b10);
    rc(OFS_STAT, 32'h20, 32'h20);
    wr(OFS_CTRL, 32'h1);
    inrx(0, 2'b01);
    // iso switch queues the part-filled bank at a frame start; kill drops it
    wr(OFS_CFG, 32'h11);
    wr(OFS_DATA, 32'h77);
    sof <= 1'b1;
    @(posedge clk);
    sof <= 1'b0;
    repeat (2) @(posedge clk);
    rc(OFS_STAT, 32'h200, 32'h200);
    wr(OFS_CTRL, 32'h2);
    rc(OFS_STAT, 32'h200, 32'h0);
    // no further frame start: the substitute one flags and counts
    wr(OFS_STAT, 32'h100);
    repeat (45) @(posedge clk);
    rc(OFS_FRAME, 32'h7FF, 32'h1);
    rc(OFS_STAT, 32'h100, 32'h100);
    conclude();
  end
endmodule
`default_nettype wire
